// ==== rtl/ocmc_pkg.sv ====
// Package for the output channel mute control block.
// Assumes a single 125 MHz system clock and an APB register port.
package ocmc_pkg;
  localparam int          NUM_CHAN          = 8;
  // Registers are word-indexed: the byte address is four times the index
  localparam logic [9:0]  IDX_AUTO_DISABLE  = 10'h016;
  localparam logic [9:0]  IDX_MUTE_STYLE    = 10'h015;
  localparam logic [11:0] ADDR_AUTO_DISABLE = {IDX_AUTO_DISABLE, 2'h0};
  localparam logic [11:0] ADDR_MUTE_STYLE   = {IDX_MUTE_STYLE, 2'h0};
  localparam logic [11:0] ADDR_CHAN_MODE    = 12'h100;
  localparam logic [11:0] ADDR_STATUS       = 12'h104;
  localparam logic [7:0]  AUTO_DISABLE_RST  = 8'hFF;
  localparam logic [1:0]  MUTE_STYLE_RST    = 2'h1;
  localparam logic [31:0] READ_ZERO         = 32'h0000_0000;

  typedef enum logic [1:0] {
    OCMC_STYLE_BYPASS,
    OCMC_STYLE_VCM,
    OCMC_STYLE_HIGH,
    OCMC_STYLE_RAIL
  } ocmc_style_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ocmc_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } ocmc_apb_rsp_t;

  // Driver controls for one channel: p/n leg enable and forced level, power-down
  typedef struct packed {
    logic pdown;
    logic p_run;
    logic p_level;
    logic n_run;
    logic n_level;
  } ocmc_drv_t;
endpackage

// ==== rtl/ocmc_chan_sync.sv ====
// Per-channel mute resynchronizer on the channel's output clock enable.
// Assumes chan_clk_en marks the low phase of that channel's output clock.
module ocmc_chan_sync (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic chan_clk_en,
  input  wire logic mute_req,
  output logic      mute_act
);
  import ocmc_pkg::*;
  logic next_mute_act;

  // Mute changes only at a clock-low boundary, so no runt pulse [R9]
  always_comb begin
    next_mute_act = mute_act;
    if (chan_clk_en) begin
      next_mute_act = mute_req;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mute_act <= 1'b0;
    end else begin
      mute_act <= next_mute_act;
    end
  end

  a_mute_edge_aligned: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R9]
    $changed(mute_act) |-> $past(chan_clk_en))
    else $error("mute changed away from a channel clock boundary");
endmodule

// ==== rtl/ocmc_top.sv ====
// Output channel mute control: APB registers, mute decision and channel-4 driver state.
// Assumes ref_valid and chan_clk_en arrive from other domains and are synchronised here.
// Overview of operation
// (R1) A two-bit channel-4 muted drive style field sits in bits 1:0, resets to 1, nonvolatile; here it is a flop that returns to 1 on every rst_n.
// (R2) Style 0 bypasses mute, style 1 idles to common mode or runs P and lows N, style 2 forces.
// (R3) Style 3 holds P at the rail and N at ground differentially, or both legs low single-ended.
// (R4) Software is advised to program the channel-4 style to 3.
// (R5) The style only shapes the muted state; the auto-disable bit and reference validity decide muting.
// (R6) An eight-bit auto-disable register holds one bit per channel, each reset to 1.
// (R7) A set auto-disable bit mutes its channel while the selected reference is invalid.
// (R8) A clear auto-disable bit keeps its channel running regardless of reference validity.
// (R9) Mute entry and exit are resynchronised to each channel's output clock.
module ocmc_top (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire ocmc_pkg::ocmc_apb_req_t apb_req,
  output ocmc_pkg::ocmc_apb_rsp_t      apb_rsp,
  input  wire logic                    ref_valid,
  input  wire logic [7:0]              chan_clk_en,
  output logic [7:0]                   chan_muted,
  output ocmc_pkg::ocmc_drv_t          chan4_drv
);
  import ocmc_pkg::*;

  logic [7:0]    auto_disable;
  logic [1:0]    chan4_muted_drive_style;
  logic          chan4_single_ended;
  logic [7:0]    next_auto_disable;
  logic [1:0]    next_style;
  logic          next_single_ended;
  ocmc_apb_rsp_t next_rsp;
  logic [1:0]    valid_sync;
  logic [7:0]    en_meta;
  logic [7:0]    en_sync;
  logic [7:0]    mute_req;
  logic [7:0]    mute_act;
  ocmc_drv_t     next_drv;
  logic          wr_acc;
  logic [7:0]    stay_clear;

  assign wr_acc = apb_req.psel && apb_req.penable && apb_req.pwrite;

  // Address map check for the bus response
  function automatic logic addr_known(input logic [11:0] addr);
    addr_known = (addr == ADDR_AUTO_DISABLE) || (addr == ADDR_MUTE_STYLE)
                 || (addr == ADDR_CHAN_MODE) || (addr == ADDR_STATUS);
  endfunction

  // Zero wait states: the answer is registered at the setup edge, so it
  // already stands at the access edge; writes land at the access edge
  always_comb begin
    next_auto_disable = auto_disable;
    next_style        = chan4_muted_drive_style;
    next_single_ended = chan4_single_ended;
    next_rsp          = apb_rsp;
    if (apb_req.psel && !apb_req.penable) begin
      next_rsp         = '{pready: 1'b1, prdata: READ_ZERO, pslverr: 1'b0};
      next_rsp.pslverr = !addr_known(apb_req.paddr)
                         || (apb_req.pwrite && apb_req.paddr == ADDR_STATUS);
      if (!apb_req.pwrite) begin
        unique case (apb_req.paddr)
          ADDR_AUTO_DISABLE: next_rsp.prdata = {24'h00_0000, auto_disable};
          ADDR_MUTE_STYLE:   next_rsp.prdata = {30'h0000_0000, chan4_muted_drive_style};
          ADDR_CHAN_MODE:    next_rsp.prdata = {31'h0000_0000, chan4_single_ended};
          ADDR_STATUS:       next_rsp.prdata = {23'h00_0000, valid_sync[1], mute_act};
          default:           next_rsp.prdata = READ_ZERO;
        endcase
      end
    end
    if (wr_acc) begin
      unique case (apb_req.paddr)
        ADDR_AUTO_DISABLE: next_auto_disable = apb_req.pwdata[7:0]; // [R6]
        ADDR_MUTE_STYLE:   next_style        = apb_req.pwdata[1:0]; // [R1]
        ADDR_CHAN_MODE:    next_single_ended = apb_req.pwdata[0];
        default:           next_single_ended = chan4_single_ended;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_disable            <= AUTO_DISABLE_RST; // [R6]
      chan4_muted_drive_style <= MUTE_STYLE_RST; // [R1]
      chan4_single_ended      <= 1'b0;
      apb_rsp                 <= '{pready: 1'b1, prdata: READ_ZERO, pslverr: 1'b0};
    end else begin
      auto_disable            <= next_auto_disable;
      chan4_muted_drive_style <= next_style;
      chan4_single_ended      <= next_single_ended;
      apb_rsp                 <= next_rsp;
    end
  end

  // Pin synchronisers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_sync <= 2'b00;
      en_meta    <= 8'h00;
      en_sync    <= 8'h00;
    end else begin
      valid_sync <= {valid_sync[0], ref_valid};
      en_meta    <= chan_clk_en;
      en_sync    <= en_meta;
    end
  end

  // Mute only when enabled and the selected reference is invalid [R7] [R8] [R5]
  assign mute_req = auto_disable & {NUM_CHAN{~valid_sync[1]}};

  // Channels that may not start a mute in the next cycle
  assign stay_clear = ~auto_disable & ~mute_act;

  for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
    ocmc_chan_sync u_sync (
      .sys_clk     (sys_clk),
      .rst_n       (rst_n),
      .chan_clk_en (en_sync[i]),
      .mute_req    (mute_req[i]),
      .mute_act    (mute_act[i])
    );
  end

  // Channel-4 driver state from muted style and output mode
  always_comb begin
    next_drv = '{pdown: 1'b0, p_run: 1'b1, p_level: 1'b0, n_run: 1'b1, n_level: 1'b0};
    if (mute_act[4]) begin
      unique case (ocmc_style_t'(chan4_muted_drive_style))
        OCMC_STYLE_BYPASS: ; // [R2]
        OCMC_STYLE_VCM: begin
          if (chan4_single_ended) begin
            next_drv.n_run = 1'b0; // [R2]
          end else begin
            next_drv.pdown = 1'b1; // [R2]
            next_drv.p_run = 1'b0;
            next_drv.n_run = 1'b0;
          end
        end
        OCMC_STYLE_HIGH: begin
          next_drv.p_run = 1'b0; // [R2]
          if (!chan4_single_ended) begin
            next_drv.n_run   = 1'b0;
            next_drv.p_level = 1'b1;
          end
        end
        OCMC_STYLE_RAIL: begin
          next_drv.p_run   = 1'b0; // [R3]
          next_drv.n_run   = 1'b0;
          next_drv.p_level = !chan4_single_ended;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      chan_muted <= 8'h00;
      chan4_drv  <= '{pdown: 1'b0, p_run: 1'b1, p_level: 1'b0, n_run: 1'b1, n_level: 1'b0};
    end else begin
      chan_muted <= mute_act;
      chan4_drv  <= next_drv;
    end
  end

  a_clear_never_mutes: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R8]
    (stay_clear != 8'h00) |=> ($past(stay_clear) & mute_act) == 8'h00)
    else $error("channel muted with auto-disable clear");
  a_valid_never_mutes: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R7]
    valid_sync[1] |=> (mute_act & ~$past(mute_act)) == 8'h00)
    else $error("channel muted while reference valid");
  a_mute_follows_req: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R7]
    (mute_req[4] && en_sync[4]) |=> ##1 chan_muted[4])
    else $error("channel 4 failed to mute");
  a_bypass_runs: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
    (chan4_muted_drive_style == 2'h0) |=> chan4_drv.p_run && chan4_drv.n_run)
    else $error("bypass style stopped the driver");
  a_rail_legs: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R3]
    (mute_act[4] && chan4_muted_drive_style == 2'h3) |=> !chan4_drv.p_run && !chan4_drv.n_run)
    else $error("style 3 left a leg running");
  a_unmuted_runs: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R5]
    !mute_act[4] |=> chan4_drv.p_run && chan4_drv.n_run && !chan4_drv.pdown)
    else $error("style changed an unmuted driver");
  a_write_takes: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R6]
    (wr_acc && apb_req.paddr == ADDR_AUTO_DISABLE) |=> auto_disable == $past(apb_req.pwdata[7:0]))
    else $error("auto-disable write lost");
  a_style_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R1]
    (wr_acc && apb_req.paddr == ADDR_MUTE_STYLE)
      |=> chan4_muted_drive_style == $past(apb_req.pwdata[1:0]))
    else $error("style write lost");
  a_status_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R6]
    (wr_acc && apb_req.paddr == ADDR_STATUS)
      |=> $stable(auto_disable) && $stable(chan4_muted_drive_style))
    else $error("status write changed a register");
  a_read_data: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R6]
    (apb_req.psel && !apb_req.penable && !apb_req.pwrite
      && apb_req.paddr == ADDR_AUTO_DISABLE)
      |=> apb_rsp.prdata == {24'h00_0000, $past(auto_disable)})
    else $error("auto-disable read data wrong");
  a_read_style: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R1]
    (apb_req.psel && !apb_req.penable && !apb_req.pwrite
      && apb_req.paddr == ADDR_MUTE_STYLE)
      |=> apb_rsp.prdata == {30'h0000_0000, $past(chan4_muted_drive_style)})
    else $error("style read data wrong");

  // Muted drive state for styles 1 to 3 in both output modes
  a_vcm_powerdown: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
    (mute_act[4] && chan4_muted_drive_style == OCMC_STYLE_VCM && !chan4_single_ended)
      |=> chan4_drv.pdown && !chan4_drv.p_run && !chan4_drv.n_run)
    else $error("style 1 differential driver not powered down");
  a_vcm_single: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
    (mute_act[4] && chan4_muted_drive_style == OCMC_STYLE_VCM && chan4_single_ended)
      |=> chan4_drv.p_run && !chan4_drv.n_run && !chan4_drv.n_level && !chan4_drv.pdown)
    else $error("style 1 single-ended legs wrong");
  a_high_diff: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
    (mute_act[4] && chan4_muted_drive_style == OCMC_STYLE_HIGH && !chan4_single_ended)
      |=> !chan4_drv.p_run && chan4_drv.p_level && !chan4_drv.n_run && !chan4_drv.n_level)
    else $error("style 2 differential output not high");
  a_high_single: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
    (mute_act[4] && chan4_muted_drive_style == OCMC_STYLE_HIGH && chan4_single_ended)
      |=> !chan4_drv.p_run && !chan4_drv.p_level && chan4_drv.n_run)
    else $error("style 2 single-ended legs wrong");
  a_rail_levels: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R3]
    (mute_act[4] && chan4_muted_drive_style == OCMC_STYLE_RAIL)
      |=> chan4_drv.p_level == !$past(chan4_single_ended) && !chan4_drv.n_level)
    else $error("style 3 leg levels wrong");
endmodule

// ==== dv/ocmc_clk_model.sv ====
// Model of the eight downstream channel clocks seen by the mute block.
// Assumes the bench clock; each channel's low phase is marked by a high enable.
module ocmc_clk_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  output logic      [7:0] chan_clk_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
  // Channels run at three rates in two phases; channels 0 and 6, and 1 and 7, share the same edges
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      chan_clk_en[i] = cnt[i % 3] ^ i[0];
    end
  end
endmodule

// ==== dv/ocmc_top_bench.sv ====
// Self-checking bench for the output channel mute control block.
// Assumes APB answers as the design declares and the channel clock model above.
module ocmc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ocmc_pkg::*;
  logic          sys_clk = 1'b0;
  logic          rst_n = 1'b0;
  logic          ref_valid = 1'b1;
  ocmc_apb_req_t req = '0;
  ocmc_apb_rsp_t rsp;
  logic [7:0]    clk_en;
  logic [7:0]    muted;
  ocmc_drv_t     drv;
  logic [31:0]   rd;
  logic          err;
  int            fails = 0;
  int            n_compared = 0;
  always #4 sys_clk = ~sys_clk;
  ocmc_clk_model peer (.sys_clk(sys_clk), .rst_n(rst_n), .chan_clk_en(clk_en));
  ocmc_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .apb_req(req), .apb_rsp(rsp),
    .ref_valid(ref_valid), .chan_clk_en(clk_en), .chan_muted(muted), .chan4_drv(drv));

  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task wait_mute(input logic [7:0] exp);
    int n;
    n = 0;
    while (muted !== exp && n < 60) begin
      @(posedge sys_clk);
      n++;
    end
    repeat (2) @(posedge sys_clk);
    chk("chan_muted", {24'h0, exp}, {24'h0, muted});
  endtask

  task t_reset;
    xfer(1'b0, ADDR_AUTO_DISABLE, 32'h0);
    chk("auto_disable", 32'h0000_00ff, rd);
    xfer(1'b0, ADDR_MUTE_STYLE, 32'h0);
    chk("mute_style", 32'h0000_0001, rd);
    xfer(1'b0, 12'h0f0, 32'h0);
    chk("pslverr", 32'h0000_0001, {31'h0, err});
    xfer(1'b0, ADDR_STATUS, 32'h0);
    chk("status", 32'h0000_0100, rd);
    xfer(1'b0, ADDR_CHAN_MODE, 32'h0);
    chk("chan_mode", 32'h0000_0000, rd);
    xfer(1'b1, ADDR_STATUS, 32'hffff_ffff);
    chk("pslverr", 32'h0000_0001, {31'h0, err});
    chk("chan_muted", 32'h0, {24'h0, muted});
  endtask

  task t_mute;
    ref_valid <= 1'b0;
    wait_mute(8'hff);
    chk("pdown", 32'h1, {31'h0, drv.pdown});
    xfer(1'b1, ADDR_AUTO_DISABLE, 32'h0000_005a);
    chk("pslverr", 32'h0000_0000, {31'h0, err});
    wait_mute(8'h5a);
    xfer(1'b1, ADDR_MUTE_STYLE, 32'hffff_fffe);
    xfer(1'b0, ADDR_MUTE_STYLE, 32'h0);
    chk("mute_style", 32'h0000_0002, rd);
  endtask

  task t_styles;
    logic [4:0] e;
    logic [4:0] m;
    for (int se = 0; se < 2; se++) begin
      xfer(1'b1, ADDR_CHAN_MODE, 32'(se));
      for (int s = 0; s < 4; s++) begin
        xfer(1'b1, ADDR_MUTE_STYLE, 32'(s));
        repeat (8) @(posedge sys_clk);
        case ({se[0], s[1:0]})
          3'b001: e = 5'b10000;
          3'b010, 3'b011: e = 5'b00100;
          3'b101: e = 5'b01000;
          3'b110: e = 5'b00010;
          3'b111: e = 5'b00000;
          default: e = 5'b01010;
        endcase
        m = {3'b110 | {2'b00, ~e[3]}, 1'b1, ~e[1]};
        if (se == 0 && s == 1) begin
          m = 5'b10000;
        end
        chk("chan4_drv", {27'h0, e & m}, {27'h0, drv & m});
        chk("chan_muted", 32'h0000_005a, {24'h0, muted});
      end
    end
  endtask

  task t_release;
    ref_valid <= 1'b1;
    wait_mute(8'h00);
    chk("chan4_drv", 32'h0000_000a, {27'h0, drv & 5'b11010});
    xfer(1'b1, ADDR_MUTE_STYLE, 32'h0000_0003);
    xfer(1'b0, ADDR_MUTE_STYLE, 32'h0);
    chk("mute_style", 32'h0000_0003, rd);
  endtask

  task t_mid_reset;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset;
  endtask

  task finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #160000;
    fails++;
    finish_test;
  end

  initial begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset;
    t_mute;
    t_styles;
    t_release;
    t_mid_reset;
    finish_test;
  end
endmodule
